// ### src/flash_protection_controller.sv
// Flash sequencer with block protection, commit store and status flags
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module flash_protection_controller #(
    parameter int unsigned BLOCKS      = 16,
    parameter int unsigned FLASH_WORDS = 8192,
    parameter int unsigned PROG_US     = 50,
    parameter int unsigned ERASE_US    = 20000,
    parameter int unsigned COMMIT_US   = 50
) (
    // Clock, resets, enable
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire logic                     factory_resetn,
    input  wire logic                     ce,
    // Register port
    input  wire flash_ctrl_pkg::reg_req_t reg_req,
    output logic [31:0]                   reg_rdata,
    // Flash read port
    input  wire flash_ctrl_pkg::flash_rd_req_t flash_rd,
    output logic [31:0]                   flash_rdata,
    output logic                          bus_fault,
    // Interrupt and debug
    output logic                          irq,
    output logic                          debug_port_enable,
    output logic                          jtag_tap_enable
);

    localparam logic [31:0] IMPL_MASK = 32'((64'h1 << BLOCKS) - 64'h1);
    localparam logic [31:0] DEBUG_MASK = 32'h3 << flash_ctrl_pkg::DEBUG_LSB;
    localparam int unsigned WIDX_W = $clog2(FLASH_WORDS);
    localparam logic [15:0] PROG_LEFT   = 16'(PROG_US - 1);
    localparam logic [15:0] ERASE_LEFT  = 16'(ERASE_US - 1);
    localparam logic [15:0] COMMIT_LEFT = 16'(COMMIT_US - 1);
    localparam logic [7:0]  SWEEP_LAST  = 8'(flash_ctrl_pkg::PAGE_WORDS - 1);

    // Flash array
    logic [31:0] mem [FLASH_WORDS];

    // Committed store
    logic [31:0] nv_pe_q;
    logic [31:0] nv_pe_d;
    logic [31:0] nv_re_q;
    logic [31:0] nv_re_d;

    // Software registers
    logic [flash_ctrl_pkg::FA_W-1:0] fa_q;
    logic [flash_ctrl_pkg::FA_W-1:0] fa_d;
    logic [31:0]                     fd_q;
    logic [31:0]                     fd_d;
    logic [1:0]                      mask_q;
    logic [1:0]                      mask_d;
    logic [1:0]                      raw_q;
    logic [1:0]                      raw_d;
    logic [31:0]                     pe_q;
    logic [31:0]                     pe_d;
    logic [31:0]                     re_q;
    logic [31:0]                     re_d;
    logic [7:0]                      usec_q;
    logic [7:0]                      usec_d;
    logic                            load_q;
    logic                            load_d;
    logic                            dbg_en_q;
    logic                            dbg_en_d;

    // Sequencer
    flash_ctrl_pkg::seq_state_t      state_q;
    flash_ctrl_pkg::seq_state_t      state_d;
    logic [7:0]                      div_q;
    logic [7:0]                      div_d;
    logic [15:0]                     left_q;
    logic [15:0]                     left_d;
    logic [7:0]                      sweep_q;
    logic [7:0]                      sweep_d;

    // Outputs
    logic [31:0]                     reg_rdata_d;
    logic [31:0]                     flash_rdata_d;
    logic                            bus_fault_d;
    logic                            irq_d;

    // Decoded strobes and sequencer outputs
    logic                            key_ok;
    logic                            cmd_write;
    logic                            cmd_erase;
    logic                            cmd_commit;
    logic                            region_open;
    logic                            us_tick;
    logic                            time_done;
    logic                            set_access;
    logic                            set_prog;
    logic                            commit_done;
    logic                            mem_we;
    logic                            mem_and;
    logic [WIDX_W-1:0]               mem_widx;
    logic [WIDX_W-1:0]               rd_widx;
    logic [3:0]                      rd_region;

    // Command decode
    always_comb
    begin
        key_ok      = reg_req.wr && (reg_req.addr == flash_ctrl_pkg::OFF_CTRL)
                      && (reg_req.wdata[31:16] == flash_ctrl_pkg::WRITE_KEY);
        cmd_write   = key_ok && reg_req.wdata[flash_ctrl_pkg::CTRL_WRITE_BIT];
        cmd_erase   = key_ok && reg_req.wdata[flash_ctrl_pkg::CTRL_ERASE_BIT];
        cmd_commit  = key_ok && reg_req.wdata[flash_ctrl_pkg::CTRL_COMMIT_BIT];
        region_open = pe_q[fa_q[flash_ctrl_pkg::FA_W-1:flash_ctrl_pkg::REGION_LSB]];
        us_tick     = (div_q == 8'h00);
        time_done   = us_tick && (left_q == 16'h0000);
    end

    // Sequencer next state
    always_comb
    begin
        state_d     = state_q;
        div_d       = div_q;
        left_d      = left_q;
        sweep_d     = sweep_q;
        set_access  = 1'b0;
        set_prog    = 1'b0;
        commit_done = 1'b0;
        mem_we      = 1'b0;
        mem_and     = 1'b0;
        mem_widx    = fa_q[flash_ctrl_pkg::FA_W-1:flash_ctrl_pkg::WORD_LSB];
        if (state_q != flash_ctrl_pkg::SEQ_IDLE)
        begin
            div_d = us_tick ? usec_q : div_q - 8'h01;
            if (us_tick && (left_q != 16'h0000))
            begin
                left_d = left_q - 16'h0001;
            end
        end
        unique case (state_q)
            flash_ctrl_pkg::SEQ_IDLE:
            begin
                div_d   = usec_q;
                sweep_d = 8'h00;
                if (cmd_write || cmd_erase)
                begin
                    if (!region_open)
                    begin
                        set_access = 1'b1;
                    end
                    else if (cmd_write)
                    begin
                        left_d  = PROG_LEFT;
                        state_d = flash_ctrl_pkg::SEQ_PROG_WAIT;
                    end
                    else
                    begin
                        left_d  = ERASE_LEFT;
                        state_d = flash_ctrl_pkg::SEQ_ERASE_WAIT;
                    end
                end
                else if (cmd_commit)
                begin
                    left_d  = COMMIT_LEFT;
                    state_d = flash_ctrl_pkg::SEQ_COMMIT_WAIT;
                end
            end
            flash_ctrl_pkg::SEQ_PROG_WAIT:
            begin
                if (time_done)
                begin
                    mem_we   = 1'b1;
                    mem_and  = 1'b1;
                    set_prog = 1'b1;
                    state_d  = flash_ctrl_pkg::SEQ_IDLE;
                end
            end
            flash_ctrl_pkg::SEQ_ERASE_WAIT:
            begin
                if (time_done)
                begin
                    state_d = flash_ctrl_pkg::SEQ_ERASE_RUN;
                end
            end
            flash_ctrl_pkg::SEQ_ERASE_RUN:
            begin
                mem_we   = 1'b1;
                mem_widx = WIDX_W'({fa_q[flash_ctrl_pkg::FA_W-1:flash_ctrl_pkg::PAGE_LSB], sweep_q});
                sweep_d  = sweep_q + 8'h01;
                if (sweep_q == SWEEP_LAST)
                begin
                    set_prog = 1'b1;
                    state_d  = flash_ctrl_pkg::SEQ_IDLE;
                end
            end
            flash_ctrl_pkg::SEQ_COMMIT_WAIT:
            begin
                if (time_done)
                begin
                    commit_done = 1'b1;
                    state_d     = flash_ctrl_pkg::SEQ_IDLE;
                end
            end
        endcase
    end

    // Committed store next value
    always_comb
    begin
        nv_pe_d = nv_pe_q;
        nv_re_d = nv_re_q;
        if (commit_done)
        begin
            if (fa_q == flash_ctrl_pkg::DEBUG_COMMIT_ADDR)
            begin
                nv_re_d = nv_re_q & re_q;
            end
            else if (fa_q[flash_ctrl_pkg::ADDR_SEL_PE_BIT])
            begin
                nv_pe_d = nv_pe_q & (pe_q | ~IMPL_MASK);
            end
            else
            begin
                nv_re_d = nv_re_q & (re_q | ~IMPL_MASK);
            end
        end
    end

    // Software register next values
    always_comb
    begin
        fa_d     = fa_q;
        fd_d     = fd_q;
        mask_d   = mask_q;
        pe_d     = pe_q;
        re_d     = re_q;
        usec_d   = usec_q;
        load_d   = 1'b0;
        dbg_en_d = dbg_en_q;
        raw_d    = raw_q;
        if (load_q)
        begin
            pe_d     = nv_pe_q;
            re_d     = nv_re_q;
            dbg_en_d = (nv_re_q[flash_ctrl_pkg::DEBUG_LSB +: 2] == flash_ctrl_pkg::DEBUG_OPEN);
        end
        else if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                flash_ctrl_pkg::OFF_ADDR:
                begin
                    fa_d = reg_req.wdata[flash_ctrl_pkg::FA_W-1:0];
                end
                flash_ctrl_pkg::OFF_DATA:
                begin
                    fd_d = reg_req.wdata;
                end
                flash_ctrl_pkg::OFF_MASK:
                begin
                    mask_d = reg_req.wdata[1:0];
                end
                flash_ctrl_pkg::OFF_MCLR:
                begin
                    raw_d = raw_q & ~reg_req.wdata[1:0];
                end
                flash_ctrl_pkg::OFF_READ_EN:
                begin
                    re_d = re_q & reg_req.wdata;
                end
                flash_ctrl_pkg::OFF_PROG_EN:
                begin
                    pe_d = pe_q & reg_req.wdata;
                end
                flash_ctrl_pkg::OFF_USEC:
                begin
                    usec_d = reg_req.wdata[7:0];
                end
                default:
                begin
                end
            endcase
        end
        if (set_access)
        begin
            raw_d[flash_ctrl_pkg::STAT_ACCESS_BIT] = 1'b1;
        end
        if (set_prog)
        begin
            raw_d[flash_ctrl_pkg::STAT_PROG_BIT] = 1'b1;
        end
    end

    // Output next values
    always_comb
    begin
        reg_rdata_d = 32'h0000_0000;
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                flash_ctrl_pkg::OFF_ADDR:    reg_rdata_d = 32'(fa_q);
                flash_ctrl_pkg::OFF_DATA:    reg_rdata_d = fd_q;
                flash_ctrl_pkg::OFF_CTRL:
                begin
                    reg_rdata_d[flash_ctrl_pkg::CTRL_WRITE_BIT]  = (state_q == flash_ctrl_pkg::SEQ_PROG_WAIT);
                    reg_rdata_d[flash_ctrl_pkg::CTRL_ERASE_BIT]  = (state_q == flash_ctrl_pkg::SEQ_ERASE_WAIT)
                                                                   || (state_q == flash_ctrl_pkg::SEQ_ERASE_RUN);
                    reg_rdata_d[flash_ctrl_pkg::CTRL_COMMIT_BIT] = (state_q == flash_ctrl_pkg::SEQ_COMMIT_WAIT);
                end
                flash_ctrl_pkg::OFF_RAW:     reg_rdata_d = 32'(raw_q);
                flash_ctrl_pkg::OFF_MASK:    reg_rdata_d = 32'(mask_q);
                flash_ctrl_pkg::OFF_MCLR:    reg_rdata_d = 32'(raw_q & mask_q);
                flash_ctrl_pkg::OFF_READ_EN: reg_rdata_d = re_q & (IMPL_MASK | DEBUG_MASK);
                flash_ctrl_pkg::OFF_PROG_EN: reg_rdata_d = pe_q & IMPL_MASK;
                flash_ctrl_pkg::OFF_USEC:    reg_rdata_d = 32'(usec_q);
                default:                     reg_rdata_d = 32'h0000_0000;
            endcase
        end
        rd_widx       = flash_rd.addr[flash_ctrl_pkg::FA_W-1:flash_ctrl_pkg::WORD_LSB];
        rd_region     = flash_rd.addr[flash_ctrl_pkg::FA_W-1:flash_ctrl_pkg::REGION_LSB];
        bus_fault_d   = flash_rd.rd && !flash_rd.fetch && !re_q[rd_region];
        flash_rdata_d = 32'h0000_0000;
        if (flash_rd.rd && !bus_fault_d)
        begin
            flash_rdata_d = mem[rd_widx];
        end
        irq_d = |(raw_q & mask_q & flash_ctrl_pkg::STAT_USED);
    end

    // Committed store, reset to factory values only by factory initialisation
    always_ff @(posedge sys_clk or negedge factory_resetn)
    begin
        if (!factory_resetn)
        begin
            nv_pe_q <= flash_ctrl_pkg::PROG_EN_RESET;
            nv_re_q <= flash_ctrl_pkg::READ_EN_RESET;
        end
        else if (ce)
        begin
            nv_pe_q <= nv_pe_d;
            nv_re_q <= nv_re_d;
        end
    end

    // Control state
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fa_q     <= '0;
            fd_q     <= 32'h0000_0000;
            mask_q   <= 2'h0;
            raw_q    <= 2'h0;
            pe_q     <= flash_ctrl_pkg::PROG_EN_RESET;
            re_q     <= flash_ctrl_pkg::READ_EN_RESET;
            usec_q   <= flash_ctrl_pkg::USEC_RESET;
            load_q   <= 1'b1;
            dbg_en_q <= 1'b0;
            state_q  <= flash_ctrl_pkg::SEQ_IDLE;
            div_q    <= 8'h00;
            left_q   <= 16'h0000;
            sweep_q  <= 8'h00;
        end
        else if (ce)
        begin
            fa_q     <= fa_d;
            fd_q     <= fd_d;
            mask_q   <= mask_d;
            raw_q    <= raw_d;
            pe_q     <= pe_d;
            re_q     <= re_d;
            usec_q   <= usec_d;
            load_q   <= load_d;
            dbg_en_q <= dbg_en_d;
            state_q  <= state_d;
            div_q    <= div_d;
            left_q   <= left_d;
            sweep_q  <= sweep_d;
        end
    end

    // Output flops
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata         <= 32'h0000_0000;
            flash_rdata       <= 32'h0000_0000;
            bus_fault         <= 1'b0;
            irq               <= 1'b0;
            debug_port_enable <= 1'b0;
            jtag_tap_enable   <= 1'b1;
        end
        else if (ce)
        begin
            reg_rdata         <= reg_rdata_d;
            flash_rdata       <= flash_rdata_d;
            bus_fault         <= bus_fault_d;
            irq               <= irq_d;
            debug_port_enable <= dbg_en_q;
            jtag_tap_enable   <= 1'b1;
        end
    end

    // Flash array writes
    always_ff @(posedge sys_clk)
    begin
        if (ce && mem_we)
        begin
            mem[mem_widx] <= mem_and ? (mem[mem_widx] & fd_q) : 32'hffff_ffff;
        end
    end

endmodule

// ### src/flash_ctrl_pkg.sv
// Constants and types shared by the flash protection controller
package flash_ctrl_pkg;

    localparam int unsigned REG_AW = 12;
    localparam int unsigned FA_W   = 15;

    // Register offsets
    localparam logic [REG_AW-1:0] OFF_ADDR      = 12'h000;
    localparam logic [REG_AW-1:0] OFF_DATA      = 12'h004;
    localparam logic [REG_AW-1:0] OFF_CTRL      = 12'h008;
    localparam logic [REG_AW-1:0] OFF_RAW       = 12'h00c;
    localparam logic [REG_AW-1:0] OFF_MASK      = 12'h010;
    localparam logic [REG_AW-1:0] OFF_MCLR      = 12'h014;
    localparam logic [REG_AW-1:0] OFF_READ_EN   = 12'h130;
    localparam logic [REG_AW-1:0] OFF_PROG_EN   = 12'h134;
    localparam logic [REG_AW-1:0] OFF_USEC      = 12'h140;

    // Control register fields
    localparam logic [15:0] WRITE_KEY       = 16'ha442;
    localparam int unsigned CTRL_WRITE_BIT  = 0;
    localparam int unsigned CTRL_ERASE_BIT  = 1;
    localparam int unsigned CTRL_COMMIT_BIT = 3;

    // Commit selection
    localparam int unsigned    ADDR_SEL_PE_BIT   = 0;
    localparam logic [FA_W-1:0] DEBUG_COMMIT_ADDR = 15'h0900;

    // Status and mask fields
    localparam int unsigned STAT_ACCESS_BIT = 0;
    localparam int unsigned STAT_PROG_BIT   = 1;
    localparam logic [1:0]  STAT_USED       = 2'h3;

    // Reset and factory values
    localparam logic [31:0] READ_EN_RESET = 32'h8000ffff;
    localparam logic [31:0] PROG_EN_RESET = 32'h0000ffff;
    localparam logic [7:0]  USEC_RESET    = 8'h31;

    // Debug field
    localparam int unsigned DEBUG_LSB  = 30;
    localparam logic [1:0]  DEBUG_OPEN = 2'h2;

    // Flash geometry
    localparam int unsigned WORD_LSB    = 2;
    localparam int unsigned PAGE_LSB    = 10;
    localparam int unsigned REGION_LSB  = 11;
    localparam int unsigned PAGE_WORDS  = 256;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic [FA_W-1:0] addr;
        logic            rd;
        logic            fetch;
    } flash_rd_req_t;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_PROG_WAIT,
        SEQ_ERASE_WAIT,
        SEQ_ERASE_RUN,
        SEQ_COMMIT_WAIT
    } seq_state_t;

endpackage

// ### tb/flash_protection_controller_monitor.sv
// Port-level assertions for the flash protection controller
`timescale 1ns/1ps
module flash_protection_controller_monitor (
    // Clock, resets, enable
    input wire logic                          sys_clk,
    input wire logic                          resetn,
    input wire logic                          factory_resetn,
    input wire logic                          ce,
    // Register port
    input wire flash_ctrl_pkg::reg_req_t      reg_req,
    input wire logic [31:0]                   reg_rdata,
    // Flash read port
    input wire flash_ctrl_pkg::flash_rd_req_t flash_rd,
    input wire logic [31:0]                   flash_rdata,
    input wire logic                          bus_fault,
    // Interrupt and debug
    input wire logic                          irq,
    input wire logic                          debug_port_enable,
    input wire logic                          jtag_tap_enable
);
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic [7:0] usec_q;
    logic [7:0] usec_d;
    logic [1:0] up_q;
    logic [1:0] up_d;
    logic       wr_go;

    assign wr_go = ce && reg_req.wr;

    // Shadow of mask and reload, cycles since reset
    always_comb
    begin
        mask_d = mask_q;
        usec_d = usec_q;
        up_d   = (ce && up_q != 2'h3) ? up_q + 2'h1 : up_q;
        if (wr_go && reg_req.addr == flash_ctrl_pkg::OFF_MASK)
        begin
            mask_d = reg_req.wdata[1:0];
        end
        if (wr_go && reg_req.addr == flash_ctrl_pkg::OFF_USEC)
        begin
            usec_d = reg_req.wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mask_q <= 2'h0;
            usec_q <= flash_ctrl_pkg::USEC_RESET;
            up_q   <= 2'h0;
        end
        else
        begin
            mask_q <= mask_d;
            usec_q <= usec_d;
            up_q   <= up_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence clear_access;
        wr_go && reg_req.addr == flash_ctrl_pkg::OFF_MCLR && reg_req.wdata[0];
    endsequence

    sequence read_raw;
        ce && reg_req.rd && reg_req.addr == flash_ctrl_pkg::OFF_RAW;
    endsequence

    chk_tap_alive:
        assert property (jtag_tap_enable)
        else $error("Test access port disabled");
    chk_fetch_served:
        assert property (ce && flash_rd.rd && flash_rd.fetch |=> !bus_fault)
        else $error("Fault on instruction fetch");
    chk_fault_no_data:
        assert property (bus_fault |-> flash_rdata == 32'h0)
        else $error("Data returned with fault");
    chk_fault_needs_read:
        assert property (ce && !flash_rd.rd |=> !bus_fault)
        else $error("Fault without data read");
    chk_masked_subset:
        assert property (ce && reg_req.rd && reg_req.addr == flash_ctrl_pkg::OFF_MCLR
            |=> (reg_rdata[1:0] & ~mask_q) == 2'h0)
        else $error("Masked status shows unmasked source");
    chk_irq_masked_off:
        assert property (mask_q == 2'h0 |=> !irq)
        else $error("Interrupt with all sources masked");
    chk_clear_access:
        assert property (clear_access ##1 read_raw |=> !reg_rdata[0])
        else $error("Access status not cleared");
    chk_debug_settled:
        assert property (up_q == 2'h3 |-> $stable(debug_port_enable))
        else $error("Debug enable changed outside power-up");
    chk_reload_read:
        assert property (ce && reg_req.rd && reg_req.addr == flash_ctrl_pkg::OFF_USEC
            |=> reg_rdata == {24'h0, usec_q})
        else $error("Reload value wrong");
endmodule

bind flash_protection_controller flash_protection_controller_monitor i_flash_protection_controller_monitor (.*);

// ### tb/cpu_bus_model.sv
// Processor-side master for the flash controller ports
`timescale 1ns/1ps
module cpu_bus_model (
    // Clock
    input  wire logic                     sys_clk,
    // Register port
    output flash_ctrl_pkg::reg_req_t      reg_req,
    input  wire logic [31:0]              reg_rdata,
    // Flash read port
    output flash_ctrl_pkg::flash_rd_req_t flash_rd,
    input  wire logic [31:0]              flash_rdata,
    input  wire logic                     bus_fault
);
    initial
    begin
        reg_req  = '0;
        flash_rd = '0;
    end

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic fl_rd(input logic [14:0] a, input logic fe, output logic [31:0] d, output logic f);
        @(posedge sys_clk);
        flash_rd <= '{addr: a, rd: 1'b1, fetch: fe};
        @(posedge sys_clk);
        flash_rd.rd <= 1'b0;
        #1 d = flash_rdata;
        f = bus_fault;
    endtask

    // Data, address, then keyed command
    task automatic cmd(input logic [14:0] a, input logic [31:0] d, input logic [15:0] bits);
        reg_wr(flash_ctrl_pkg::OFF_DATA, d);
        reg_wr(flash_ctrl_pkg::OFF_ADDR, {17'h0, a});
        reg_wr(flash_ctrl_pkg::OFF_CTRL, {flash_ctrl_pkg::WRITE_KEY, bits});
    endtask

    task automatic set_reload(input logic [7:0] mhz);
        reg_wr(flash_ctrl_pkg::OFF_USEC, {24'h0, mhz - 8'h1});
    endtask
endmodule

// ### tb/flash_protection_controller_test.sv
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps
module flash_protection_controller_test;
    logic                          sys_clk;
    logic                          resetn;
    logic                          factory_resetn;
    logic                          ce;
    flash_ctrl_pkg::reg_req_t      reg_req;
    logic [31:0]                   reg_rdata;
    flash_ctrl_pkg::flash_rd_req_t flash_rd;
    logic [31:0]                   flash_rdata;
    logic                          bus_fault;
    logic                          irq;
    logic                          debug_port_enable;
    logic                          jtag_tap_enable;
    int                            mismatches = 0;
    int                            tests_run = 0;
    int                            cycles = 0;

    flash_protection_controller #(.PROG_US(2), .ERASE_US(2), .COMMIT_US(2)) i_flash_protection_controller (.*);

    cpu_bus_model i_cpu_bus_model (.*);

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        if (mismatches == 0 && tests_run > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_cpu_bus_model.reg_rd(a, d);
        chk(n, d, e);
    endtask

    task automatic fl_chk(input logic [14:0] a, input logic fe, input logic [31:0] e, input logic ef);
        logic [31:0] d;
        logic        f;
        i_cpu_bus_model.fl_rd(a, fe, d, f);
        chk("flash data", d, e);
        chk("bus fault", 32'(f), 32'(ef));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_cpu_bus_model.reg_wr(a, d);
    endtask

    task automatic wait_idle();
        logic [31:0] d;
        int          n;
        n = 0;
        d = 32'h1;
        while (d !== 32'h0 && n < 400)
        begin
            i_cpu_bus_model.reg_rd(12'h008, d);
            n++;
        end
        chk("idle", d, 32'h0);
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic t_reset_values();
        rd_chk("reload", 12'h140, 32'h00000031);
        rd_chk("read_en", 12'h130, 32'h8000ffff);
        rd_chk("prog_en", 12'h134, 32'h0000ffff);
        chk("tap", 32'(jtag_tap_enable), 32'h1);
        chk("debug", 32'(debug_port_enable), 32'h1);
        wr(12'h018, 32'hffffffff);
        rd_chk("unmapped", 12'h018, 32'h0);
    endtask

    task automatic t_program_erase();
        i_cpu_bus_model.set_reload(8'd4);
        rd_chk("reload", 12'h140, 32'h00000003);
        wr(12'h008, 32'h00000002);
        rd_chk("keyless", 12'h008, 32'h0);
        i_cpu_bus_model.cmd(15'h0000, 32'h0, 16'h0002);
        wait_idle();
        fl_chk(15'h0000, 1'b0, 32'hffffffff, 1'b0);
        fl_chk(15'h03fc, 1'b0, 32'hffffffff, 1'b0);
        rd_chk("raw", 12'h00c, 32'h2);
        i_cpu_bus_model.cmd(15'h0004, 32'ha5a50f0f, 16'h0001);
        wait_idle();
        i_cpu_bus_model.cmd(15'h0004, 32'h0ff0ffff, 16'h0001);
        wait_idle();
        fl_chk(15'h0004, 1'b0, 32'h05a00f0f, 1'b0);
        wr(12'h014, 32'h0);
        rd_chk("raw", 12'h00c, 32'h2);
        wr(12'h014, 32'h2);
        rd_chk("raw", 12'h00c, 32'h0);
    endtask

    task automatic t_program_protect();
        i_cpu_bus_model.cmd(15'h0800, 32'h0, 16'h0002);
        wait_idle();
        i_cpu_bus_model.cmd(15'h0c00, 32'h0, 16'h0002);
        wait_idle();
        i_cpu_bus_model.cmd(15'h0c04, 32'h0, 16'h0001);
        wait_idle();
        wr(12'h014, 32'h3);
        wr(12'h134, 32'hfffffffd);
        rd_chk("prog_en", 12'h134, 32'h0000fffd);
        wr(12'h010, 32'h1);
        i_cpu_bus_model.cmd(15'h0800, 32'h0, 16'h0001);
        rd_chk("raw", 12'h00c, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        rd_chk("masked", 12'h014, 32'h1);
        fl_chk(15'h0800, 1'b0, 32'hffffffff, 1'b0);
        wr(12'h014, 32'h1);
        wr(12'h010, 32'h0);
        i_cpu_bus_model.cmd(15'h0c00, 32'h0, 16'h0002);
        rd_chk("raw", 12'h00c, 32'h1);
        chk("irq", 32'(irq), 32'h0);
        fl_chk(15'h0c04, 1'b0, 32'h0, 1'b0);
        wr(12'h014, 32'h1);
    endtask

    task automatic t_read_protect();
        wr(12'h130, 32'hfffffffe);
        fl_chk(15'h0004, 1'b0, 32'h0, 1'b1);
        fl_chk(15'h0004, 1'b1, 32'h05a00f0f, 1'b0);
        do_reset();
        rd_chk("read_en", 12'h130, 32'h8000ffff);
        fl_chk(15'h0004, 1'b0, 32'h05a00f0f, 1'b0);
    endtask

    task automatic t_commit();
        wr(12'h130, 32'hfffffffd);
        wr(12'h134, 32'hfffffffb);
        i_cpu_bus_model.cmd(15'h0000, 32'h0, 16'h0008);
        rd_chk("commit busy", 12'h008, 32'h8);
        wait_idle();
        i_cpu_bus_model.cmd(15'h0001, 32'h0, 16'h0008);
        wait_idle();
        wr(12'h130, 32'h3fffffff);
        i_cpu_bus_model.cmd(15'h0900, 32'h0, 16'h0008);
        wait_idle();
        chk("debug", 32'(debug_port_enable), 32'h1);
        do_reset();
        rd_chk("read_en", 12'h130, 32'h0000fffd);
        rd_chk("prog_en", 12'h134, 32'h0000fffb);
        chk("debug", 32'(debug_port_enable), 32'h0);
        chk("tap", 32'(jtag_tap_enable), 32'h1);
    endtask

    initial
    begin
        resetn = 1'b0;
        factory_resetn = 1'b0;
        ce = 1'b1;
        repeat (3) @(posedge sys_clk);
        factory_resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset_values();
        t_program_erase();
        t_program_protect();
        t_read_protect();
        t_commit();
        summarize();
    end
endmodule
